// File: hw/irq_arb_pkg.sv
`default_nettype none
package irq_arb_pkg;
    // sources in polling order, index 0 polled first
    localparam int NUM_SRC = 10;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_TMR0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_TMR1 = 3;
    localparam int SRC_PCA = 4;
    localparam int SRC_UART = 5;
    localparam int SRC_TMR2 = 6;
    localparam int SRC_CAN = 7;
    localparam int SRC_ADC = 8;
    localparam int SRC_CANTIM = 9;

    localparam logic [15:0] VEC_EXT0 = 16'h0003;
    localparam logic [15:0] VEC_TMR0 = 16'h000B;
    localparam logic [15:0] VEC_EXT1 = 16'h0013;
    localparam logic [15:0] VEC_TMR1 = 16'h001B;
    localparam logic [15:0] VEC_UART = 16'h0023;
    localparam logic [15:0] VEC_TMR2 = 16'h002B;
    localparam logic [15:0] VEC_PCA = 16'h0033;
    localparam logic [15:0] VEC_CAN = 16'h003B;
    localparam logic [15:0] VEC_ADC = 16'h0043;
    localparam logic [15:0] VEC_CANTIM = 16'h004B;

    // register byte addresses
    localparam logic [7:0] ADDR_ENABLE = 8'h00;
    localparam logic [7:0] ADDR_PRIO_LOW = 8'h04;
    localparam logic [7:0] ADDR_PRIO_HIGH = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    localparam logic [7:0] ADDR_PCA_CTRL = 8'h14;
    localparam logic [7:0] ADDR_SERVICE = 8'h18;

    // enable register: bits 9:0 per source, global enable bit
    localparam int EN_GLOBAL_BIT = 15;
    // pca control register
    localparam int PCA_OVF_IE_BIT = 0;

    // status flag positions
    localparam int NUM_FLAG = 15;
    localparam int FL_TMR0 = 0;
    localparam int FL_TMR1 = 1;
    localparam int FL_TMR2 = 2;
    localparam int FL_TMR2_TOGGLE = 3;
    localparam int FL_UART_RX = 4;
    localparam int FL_UART_TX = 5;
    localparam int FL_PCA_OVF = 6;
    localparam int FL_PCA_MOD0 = 7;
    localparam int FL_PCA_MOD1 = 8;
    localparam int FL_CAN_TX = 9;
    localparam int FL_CAN_RX = 10;
    localparam int FL_CAN_ERR = 11;
    localparam int FL_CAN_OVR = 12;
    localparam int FL_ADC = 13;
    localparam int FL_CANTIM = 14;

    // service register fields
    localparam int SVC_INSVC_LSB = 0;
    localparam int SVC_LEVEL_LSB = 4;
    localparam int SVC_REQ_BIT = 8;
    localparam int SVC_VEC_LSB = 16;

    // reset values
    localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
    localparam logic [9:0] RST_PRIO = 10'h000;
    localparam logic [14:0] RST_MASK = 15'h0000;
    localparam logic [14:0] RST_FLAGS = 15'h0000;
endpackage
`default_nettype wire

// File: hw/sticky_flags.sv
`default_nettype none
// sticky flag bank: hardware set wins over software clear
module sticky_flags #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // set and clear strobes
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    // flags
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] flags_ff;
    logic [WIDTH-1:0] nxt_flags;

    assign nxt_flags = set | (flags_ff & ~clr);
    assign flags = flags_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= RST_VAL;
        end else begin
            flags_ff <= nxt_flags;
        end
    end
endmodule
`default_nettype wire

// File: hw/prio_select.sv
`default_nettype none
// picks the highest level request, lowest index breaks a tie
module prio_select #(
    parameter int N = 10
) (
    // requests and their levels
    input wire logic [N-1:0] req,
    input wire logic [N-1:0] lvl_hi,
    input wire logic [N-1:0] lvl_lo,
    // winner
    output logic found,
    output logic [3:0] idx,
    output logic [1:0] level
);
    always_comb begin
        found = 1'b0;
        idx = 4'h0;
        level = 2'h0;
        for (int i = 0; i < N; i++) begin
            // strictly greater keeps the earlier polled source
            if (req[i] && (!found || {lvl_hi[i], lvl_lo[i]} > level)) begin
                found = 1'b1;
                idx = 4'(i);
                level = {lvl_hi[i], lvl_lo[i]};
            end
        end
    end
endmodule
`default_nettype wire

// File: hw/four_level_interrupt_arbiter.sv
// Function
// - each source has own enable bit
// - global enable clear blocks all service
// - two priority bits give levels zero to three
// - only higher level preempts running service
// - level three service is never preempted
// - higher level wins among simultaneous requests
// - fixed polling order breaks same level ties
// - each source has fixed vector address
// - four CAN conditions share one request
// - CAN stamp timer wrap separate, polled last
// - pca overflow requests only when enabled
// - pca overflow flag cleared only by software
// - pca module flags set by hardware
// - timer0 rollover sets its overflow flag
// - timer2 toggle bit raises no request
//
// Chosen here: the register addresses and the APB register port.
`default_nettype none
module four_level_interrupt_arbiter (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external interrupt pins, active low, asynchronous
    input wire logic ext_irq_zero_n,
    input wire logic ext_irq_one_n,
    // one-cycle event pulses from peripherals
    input wire logic timer0_rollover,
    input wire logic timer1_rollover,
    input wire logic timer2_rollover,
    input wire logic timer2_toggle,
    input wire logic uart_rx_done,
    input wire logic uart_tx_done,
    input wire logic pca_counter_wrap,
    input wire logic [1:0] pca_module_event,
    input wire logic can_tx_ok,
    input wire logic can_rx_ok,
    input wire logic can_error,
    input wire logic can_buffer_overrun,
    input wire logic converter_done,
    input wire logic can_stamp_timer_wrap,
    // processor core
    input wire logic core_ack,
    input wire logic core_return,
    output logic core_req,
    output logic [15:0] core_vector,
    output logic [1:0] core_level,
    // software interrupt line
    output logic irq
);
    logic [31:0] enable_ff;
    logic [9:0] prio_low_ff;
    logic [9:0] prio_high_ff;
    logic [14:0] mask_ff;
    logic pca_ovf_ie_ff;
    logic [3:0] in_service_ff;
    logic [3:0] nxt_in_service;
    logic req_ff;
    logic [15:0] vector_ff;
    logic [1:0] level_ff;
    logic [31:0] prdata_ff;
    logic rd_err_ff;
    logic [1:0] ext0_sync_ff;
    logic [1:0] ext1_sync_ff;

    // apb decode
    wire setup_rd = psel && !penable && !pwrite;
    wire wr_en = psel && penable && pwrite;
    wire sel_enable = paddr == irq_arb_pkg::ADDR_ENABLE;
    wire sel_prio_low = paddr == irq_arb_pkg::ADDR_PRIO_LOW;
    wire sel_prio_high = paddr == irq_arb_pkg::ADDR_PRIO_HIGH;
    wire sel_status = paddr == irq_arb_pkg::ADDR_STATUS;
    wire sel_mask = paddr == irq_arb_pkg::ADDR_MASK;
    wire sel_pca = paddr == irq_arb_pkg::ADDR_PCA_CTRL;
    wire sel_service = paddr == irq_arb_pkg::ADDR_SERVICE;
    wire mapped = sel_enable || sel_prio_low || sel_prio_high ||
        sel_status || sel_mask || sel_pca || sel_service;

    // two flops on each pin before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext0_sync_ff <= 2'h3;
            ext1_sync_ff <= 2'h3;
        end else begin
            ext0_sync_ff <= {ext0_sync_ff[0], ext_irq_zero_n};
            ext1_sync_ff <= {ext1_sync_ff[0], ext_irq_one_n};
        end
    end

    // sticky event flags
    logic [14:0] flags;
    wire [14:0] flag_set;
    wire [14:0] flag_clr = (wr_en && sel_status) ? pwdata[14:0] : 15'h0000;

    assign flag_set[irq_arb_pkg::FL_TMR0] = timer0_rollover;
    assign flag_set[irq_arb_pkg::FL_TMR1] = timer1_rollover;
    assign flag_set[irq_arb_pkg::FL_TMR2] = timer2_rollover;
    assign flag_set[irq_arb_pkg::FL_TMR2_TOGGLE] = timer2_toggle;
    assign flag_set[irq_arb_pkg::FL_UART_RX] = uart_rx_done;
    assign flag_set[irq_arb_pkg::FL_UART_TX] = uart_tx_done;
    // set by the wrap itself, regardless of the interrupt enable
    assign flag_set[irq_arb_pkg::FL_PCA_OVF] = pca_counter_wrap;
    assign flag_set[irq_arb_pkg::FL_PCA_MOD0] = pca_module_event[0];
    assign flag_set[irq_arb_pkg::FL_PCA_MOD1] = pca_module_event[1];
    assign flag_set[irq_arb_pkg::FL_CAN_TX] = can_tx_ok;
    assign flag_set[irq_arb_pkg::FL_CAN_RX] = can_rx_ok;
    assign flag_set[irq_arb_pkg::FL_CAN_ERR] = can_error;
    assign flag_set[irq_arb_pkg::FL_CAN_OVR] = can_buffer_overrun;
    assign flag_set[irq_arb_pkg::FL_ADC] = converter_done;
    assign flag_set[irq_arb_pkg::FL_CANTIM] = can_stamp_timer_wrap;

    // only a status write clears, nothing in the core path does
    sticky_flags #(
        .WIDTH(irq_arb_pkg::NUM_FLAG),
        .RST_VAL(irq_arb_pkg::RST_FLAGS)
    ) u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set(flag_set),
        .clr(flag_clr),
        .flags(flags)
    );

    // source requests in polling order
    wire [9:0] src_req;
    assign src_req[irq_arb_pkg::SRC_EXT0] = !ext0_sync_ff[1];
    assign src_req[irq_arb_pkg::SRC_TMR0] = flags[irq_arb_pkg::FL_TMR0];
    assign src_req[irq_arb_pkg::SRC_EXT1] = !ext1_sync_ff[1];
    assign src_req[irq_arb_pkg::SRC_TMR1] = flags[irq_arb_pkg::FL_TMR1];
    assign src_req[irq_arb_pkg::SRC_PCA] =
        (flags[irq_arb_pkg::FL_PCA_OVF] && pca_ovf_ie_ff) ||
        flags[irq_arb_pkg::FL_PCA_MOD0] ||
        flags[irq_arb_pkg::FL_PCA_MOD1];
    assign src_req[irq_arb_pkg::SRC_UART] =
        flags[irq_arb_pkg::FL_UART_RX] || flags[irq_arb_pkg::FL_UART_TX];
    // the toggle flag is deliberately left out here
    assign src_req[irq_arb_pkg::SRC_TMR2] =
        flags[irq_arb_pkg::FL_TMR2];
    assign src_req[irq_arb_pkg::SRC_CAN] =
        flags[irq_arb_pkg::FL_CAN_TX] || flags[irq_arb_pkg::FL_CAN_RX] ||
        flags[irq_arb_pkg::FL_CAN_ERR] ||
        flags[irq_arb_pkg::FL_CAN_OVR];
    assign src_req[irq_arb_pkg::SRC_ADC] = flags[irq_arb_pkg::FL_ADC];
    assign src_req[irq_arb_pkg::SRC_CANTIM] =
        flags[irq_arb_pkg::FL_CANTIM];

    wire global_en = enable_ff[irq_arb_pkg::EN_GLOBAL_BIT];
    wire [9:0] eligible =
        src_req & enable_ff[9:0] & {10{global_en}};

    logic win_found;
    logic [3:0] win_idx;
    logic [1:0] win_level;

    // the lowest index beats an equal level, giving the polling order
    prio_select #(
        .N(irq_arb_pkg::NUM_SRC)
    ) u_select (
        .req(eligible),
        .lvl_hi(prio_high_ff),
        .lvl_lo(prio_low_ff),
        .found(win_found),
        .idx(win_idx),
        .level(win_level)
    );

    // level currently served, or none
    wire busy = |in_service_ff;
    wire [1:0] cur_level = in_service_ff[3] ? 2'h3 :
        in_service_ff[2] ? 2'h2 : in_service_ff[1] ? 2'h1 : 2'h0;
    // no level can exceed a cur_level of three, so level three is never preempted
    wire preempt_ok = !busy || (win_level > cur_level);
    wire nxt_req = win_found && preempt_ok;

    logic [15:0] win_vector;
    always_comb begin
        unique case (win_idx)
            4'h0: win_vector = irq_arb_pkg::VEC_EXT0;
            4'h1: win_vector = irq_arb_pkg::VEC_TMR0;
            4'h2: win_vector = irq_arb_pkg::VEC_EXT1;
            4'h3: win_vector = irq_arb_pkg::VEC_TMR1;
            4'h4: win_vector = irq_arb_pkg::VEC_PCA;
            4'h5: win_vector = irq_arb_pkg::VEC_UART;
            4'h6: win_vector = irq_arb_pkg::VEC_TMR2;
            4'h7: win_vector = irq_arb_pkg::VEC_CAN;
            4'h8: win_vector = irq_arb_pkg::VEC_ADC;
            4'h9: win_vector = irq_arb_pkg::VEC_CANTIM;
            default: win_vector = 16'h0000;
        endcase
    end

    // in-service stack: ack pushes the offered level, return pops the top
    wire take = core_ack && req_ff;
    wire [3:0] push_bit = take ? (4'h1 << level_ff) : 4'h0;
    wire [3:0] pop_bit = (core_return && busy) ?
        (4'h1 << cur_level) : 4'h0;
    assign nxt_in_service = (in_service_ff & ~pop_bit) | push_bit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_service_ff <= 4'h0;
            req_ff <= 1'b0;
            vector_ff <= 16'h0000;
            level_ff <= 2'h0;
        end else begin
            in_service_ff <= nxt_in_service;
            // one cycle lull after an ack so a stale offer is not retaken
            req_ff <= nxt_req && !take;
            // no winner shows a zero vector, as after reset
            vector_ff <= win_found ? win_vector : 16'h0000;
            level_ff <= win_level;
        end
    end

    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_ff <= irq_arb_pkg::RST_ENABLE;
            prio_low_ff <= irq_arb_pkg::RST_PRIO;
            prio_high_ff <= irq_arb_pkg::RST_PRIO;
            mask_ff <= irq_arb_pkg::RST_MASK;
            pca_ovf_ie_ff <= 1'b0;
        end else if (wr_en) begin
            if (sel_enable) begin
                enable_ff <= pwdata & 32'h0000_83FF;
            end
            if (sel_prio_low) begin
                prio_low_ff <= pwdata[9:0];
            end
            if (sel_prio_high) begin
                prio_high_ff <= pwdata[9:0];
            end
            if (sel_mask) begin
                mask_ff <= pwdata[14:0];
            end
            if (sel_pca) begin
                pca_ovf_ie_ff <= pwdata[irq_arb_pkg::PCA_OVF_IE_BIT];
            end
        end
    end

    // read data is captured in the setup cycle
    wire [31:0] svc_word = ({28'h0, in_service_ff} <<
            irq_arb_pkg::SVC_INSVC_LSB) |
        ({30'h0, level_ff} << irq_arb_pkg::SVC_LEVEL_LSB) |
        ({31'h0, req_ff} << irq_arb_pkg::SVC_REQ_BIT) |
        ({16'h0, vector_ff} << irq_arb_pkg::SVC_VEC_LSB);
    wire [31:0] rd_word =
        sel_enable ? enable_ff :
        sel_prio_low ? {22'h0, prio_low_ff} :
        sel_prio_high ? {22'h0, prio_high_ff} :
        sel_status ? {17'h0, flags} :
        sel_mask ? {17'h0, mask_ff} :
        sel_pca ? {31'h0, pca_ovf_ie_ff} :
        sel_service ? svc_word : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
            rd_err_ff <= 1'b0;
        end else if (psel && !penable) begin
            prdata_ff <= setup_rd ? rd_word : 32'h0000_0000;
            rd_err_ff <= !mapped;
        end
    end

    assign prdata = prdata_ff;
    assign pready = psel && penable;
    assign pslverr = psel && penable && rd_err_ff;
    assign core_req = req_ff;
    assign core_vector = vector_ff;
    assign core_level = level_ff;
    assign irq = |(flags & mask_ff);
endmodule
`default_nettype wire

// File: verif/core_model.sv
`default_nettype none
module core_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // offer and test controls
    input wire logic core_req,
    input wire logic slow,
    input wire logic ret_go,
    // answers
    output logic core_ack,
    output logic core_return
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_ff;
    // a slow core lets the offer stand three cycles, so a later winner
    // may still replace it before it is taken
    wire ready = !slow || wait_ff == 2'h3;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_ff <= 2'h0;
            core_ack <= 1'h0;
            core_return <= 1'h0;
        end else begin
            wait_ff <= core_req && !ready ? wait_ff + 2'h1 : 2'h0;
            core_ack <= core_req && !core_ack && ready;
            core_return <= ret_go;
        end
    end
endmodule
`default_nettype wire

// File: verif/irq_arb_chk.sv
`default_nettype none
module irq_arb_chk (
    // clock, reset and apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // events and core
    input wire logic timer0_rollover,
    input wire logic core_ack,
    input wire logic core_return,
    input wire logic core_req,
    input wire logic [15:0] core_vector,
    input wire logic [1:0] core_level
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic [3:0] svc_ff, nxt_svc;
    logic gen_ff;
    logic [9:0] en_ff;
    wire wr_en = psel && penable && pwrite && paddr == 8'h00;
    wire mapped = paddr <= 8'h18 && paddr[1:0] == 2'h0;
    wire [1:0] top = svc_ff[3] ? 2'h3 : svc_ff[2] ? 2'h2 : {1'h0, svc_ff[1]};
    wire [3:0] pop = !core_return ? 4'h0 : svc_ff[3] ? 4'h8
        : svc_ff[2] ? 4'h4 : svc_ff[1] ? 4'h2 : {3'h0, svc_ff[0]};
    wire [3:0] push = core_req && core_ack ? 4'h1 << core_level : 4'h0;
    assign nxt_svc = (svc_ff & ~pop) | push;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            svc_ff <= 4'h0;
            gen_ff <= 1'h0;
            en_ff <= 10'h000;
        end else begin
            svc_ff <= nxt_svc;
            if (wr_en) begin
                gen_ff <= pwdata[15];
                en_ff <= pwdata[9:0];
            end
        end
    end
    AST_PREADY:
        assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    AST_SLVERR:
        assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr does not match decode");
    AST_ACK_DROP:
        assert property (core_req && core_ack |=> !core_req)
        else $error("offer stayed up after ack");
    AST_VECTOR:
        assert property (core_req |-> core_vector[2:0] == 3'h3
            && core_vector <= 16'h004B)
        else $error("vector outside the table");
    AST_PREEMPT:
        assert property (core_req && svc_ff != 4'h0 |-> core_level > top)
        else $error("offer not above level in service");
    AST_TOP_HOLD:
        assert property (svc_ff[3] |-> !core_req)
        else $error("offer during top level service");
    AST_GLOBAL:
        assert property (!gen_ff && !$past(gen_ff) |-> !core_req)
        else $error("offer with global enable off");
    AST_T0_OFFER:
        assert property (timer0_rollover && en_ff[1] && gen_ff
            && svc_ff == 4'h0 |-> ##[1:2] core_req)
        else $error("timer0 rollover not offered");
endmodule
bind four_level_interrupt_arbiter irq_arb_chk u_chk (.*);
`default_nettype wire

// File: verif/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, slow = 1'h0, ret_go = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, en_v;
    logic [16:0] ev = 17'h0;
    logic pready, pslverr, core_ack, core_return, core_req, irq;
    logic [15:0] core_vector;
    logic [1:0] core_level;
    logic [17:0] notes[$];
    int mismatches = 0, checks_done = 0, acks = 0, served = 0;
    localparam logic [15:0] VEC[10] = '{16'h0003, 16'h000B, 16'h0013,
        16'h001B, 16'h0033, 16'h0023, 16'h002B, 16'h003B, 16'h0043, 16'h004B};
    localparam logic [7:0] ADR[5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
    localparam logic [31:0] MSK[5] = '{32'h83FF, 32'h3FF, 32'h3FF,
        32'h7FFF, 32'h1};
    localparam logic [31:0] QEN[4] = '{32'h3FF, 32'h83F7, 32'h83FF, 32'h83FF};
    localparam int QEV[4] = '{1, 3, 10, 11};
    localparam int QFL[4] = '{0, 1, 3, 6};
    localparam int POLL[5] = '{2, 3, 7, 8, 9};
    always #10 pclk = ~pclk;
    four_level_interrupt_arbiter u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_irq_zero_n(!ev[0]),
        .ext_irq_one_n(!ev[2]), .timer0_rollover(ev[1]),
        .timer1_rollover(ev[3]), .timer2_rollover(ev[6]),
        .timer2_toggle(ev[10]), .uart_rx_done(ev[5]),
        .uart_tx_done(ev[12]), .pca_counter_wrap(ev[11]),
        .pca_module_event({ev[16], ev[4]}), .can_tx_ok(ev[13]),
        .can_rx_ok(ev[7]), .can_error(ev[14]), .can_buffer_overrun(ev[15]),
        .converter_done(ev[8]), .can_stamp_timer_wrap(ev[9]),
        .core_ack(core_ack), .core_return(core_return),
        .core_req(core_req), .core_vector(core_vector),
        .core_level(core_level), .irq(irq));
    core_model u_core (.pclk(pclk), .presetn(presetn), .core_req(core_req),
        .slow(slow), .ret_go(ret_go), .core_ack(core_ack),
        .core_return(core_return));
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic fail(string n);
        mismatches++;
        $display("[ERR] %s expected answer seen none", n);
        conclude();
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20)
            fail("pready");
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic rw(logic w, logic [7:0] a, logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(w, a, x, r, e);
        if (!w)
            cmp("prdata", x, r);
        cmp("pslverr", {31'h0, a > 8'h18}, {31'h0, e});
    endtask
    task automatic en(logic [31:0] v);
        en_v = v;
        rw(1'h1, 8'h00, v);
    endtask
    task automatic note(int s, logic [1:0] l);
        notes.push_back({l, VEC[s]});
    endtask
    // ext pins are levels, so only they stay asserted after the pulse
    task automatic fire(logic [16:0] m);
        ev <= ev | m;
        @(posedge pclk);
        ev <= ev & 17'h5;
    endtask
    task automatic wait_ack();
        int n;
        for (n = 0; acks <= served && n < 300; n++)
            @(posedge pclk);
        if (acks <= served)
            fail("offer");
        served++;
    endtask
    task automatic rel(int s);
        en(en_v & ~(32'h1 << s));
        ret_go <= 1'h1;
        @(posedge pclk);
        ret_go <= 1'h0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic serve(int s);
        wait_ack();
        ev <= 17'h0;
        rel(s);
    endtask
    task automatic quiet();
        repeat (6) begin
            @(negedge pclk);
            cmp("core_req", 32'h0, {31'h0, core_req});
        end
        @(posedge pclk);
    endtask
    task automatic prio(logic [9:0] h, logic [9:0] l);
        rw(1'h1, 8'h0C, 32'h7FFF);
        rw(1'h1, 8'h08, {22'h0, h});
        rw(1'h1, 8'h04, {22'h0, l});
    endtask
    always @(negedge pclk) begin
        if (core_req === 1'h1 && core_ack === 1'h1) begin
            if (notes.size() == 0)
                fail("note");
            cmp("offer", {14'h0, notes.pop_front()},
                {14'h0, core_level, core_vector});
            acks++;
        end
    end
    initial begin
        logic [31:0] r;
        logic [9:0] hi, lo;
        int s;
        void'($urandom(21065));
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        for (int b = 0; b < 8; b++)
            rw(1'h0, 8'(b * 4), 32'h0);
        for (int b = 0; b < 5; b++) begin
            r = $urandom;
            rw(1'h1, ADR[b], r);
            rw(1'h0, ADR[b], r & MSK[b]);
        end
        rw(1'h1, 8'h1C, 32'h1);
        $display("registers done");
        for (int b = 0; b < 17; b++) begin
            s = b == 12 ? 5 : b == 16 ? 4 : b > 12 ? 7 : b;
            hi = 10'($urandom);
            lo = 10'($urandom);
            if (b == 10 || b == 11)
                continue;
            prio(hi, lo);
            en(32'h83FF);
            note(s, {hi[s], lo[s]});
            fire(17'h1 << b);
            serve(s);
        end
        $display("vectors done");
        prio(10'h0, 10'h0);
        // the register pass left a random overflow enable behind
        rw(1'h1, 8'h14, 32'h0);
        for (int b = 0; b < 4; b++) begin
            rw(1'h1, 8'h0C, 32'h7FFF);
            en(QEN[b]);
            fire(17'h1 << QEV[b]);
            quiet();
            rw(1'h0, 8'h0C, 32'h1 << QFL[b]);
        end
        note(4, 2'h0);
        rw(1'h1, 8'h14, 32'h1);
        serve(4);
        rw(1'h1, 8'h14, 32'h0);
        $display("quiet cases done");
        slow <= 1'h1;
        prio(10'h200, 10'h200);
        en(32'h3FF);
        note(9, 2'h3);
        note(1, 2'h0);
        fire(17'h202);
        en(32'h83FF);
        serve(9);
        serve(1);
        prio(10'h0, 10'h0);
        en(32'h3FF);
        fire(17'h38C);
        en(32'h83FF);
        foreach (POLL[i])
            note(POLL[i], 2'h0);
        foreach (POLL[i])
            serve(POLL[i]);
        slow <= 1'h0;
        $display("ordering done");
        prio(10'h40, 10'h9);
        en(32'h83FF);
        note(3, 2'h1);
        fire(17'h8);
        wait_ack();
        fire(17'h1);
        quiet();
        note(6, 2'h2);
        fire(17'h40);
        serve(6);
        // serve released the pin, so raise it again under level one
        fire(17'h1);
        quiet();
        note(0, 2'h1);
        rel(3);
        serve(0);
        $display("preemption done");
        en(32'h0);
        rw(1'h1, 8'h0C, 32'h7FFF);
        fire(17'h2);
        for (int b = 0; b < 4; b++) begin
            rw(1'h1, b == 3 ? 8'h0C : 8'h10, {31'h0, b != 1});
            @(negedge pclk);
            cmp("irq", {31'h0, b % 2 == 0}, {31'h0, irq});
            @(posedge pclk);
        end
        $display("interrupt line done");
        conclude();
    end
endmodule
`default_nettype wire
